/* File: hw/psw_pkg.sv */
/*
 power switch and wake control package: states, timing counts, port structs.
 assumes a 100 MHz always-on standby clock.
*/
package psw_pkg;

   // system power states
   typedef enum logic [2:0]
   {
      PSW_S0  = 3'b000,
      PSW_S1  = 3'b001,
      PSW_S3  = 3'b011,
      PSW_S5  = 3'b101,
      PSW_STB = 3'b110
   } psw_state_e;

   // after power failure policy
   localparam logic [1:0] PSW_APF_OFF  = 2'h0;
   localparam logic [1:0] PSW_APF_ON   = 2'h1;
   localparam logic [1:0] PSW_APF_LAST = 2'h2;

   localparam int unsigned PSW_CLK_MHZ     = 100;
   // hold threshold, four seconds
   localparam int unsigned PSW_HOLD_MS     = 4000;
   localparam longint unsigned PSW_HOLD_CYC_L =
      longint'(PSW_HOLD_MS) * 1000 * PSW_CLK_MHZ;
   // switch debounce, 10 ms
   localparam int unsigned PSW_DEB_US      = 10000;
   localparam int unsigned PSW_DEB_CYC     = PSW_DEB_US * PSW_CLK_MHZ;
   localparam int unsigned PSW_CNT_W       = 32;

   // wake request bit positions
   localparam int PSW_WK_SW    = 0;
   localparam int PSW_WK_RTC   = 1;
   localparam int PSW_WK_LAN   = 2;
   localparam int PSW_WK_PME   = 3;
   localparam int PSW_WK_RING  = 4;
   localparam int PSW_WK_IR    = 5;
   localparam int PSW_WK_USB   = 6;
   localparam int PSW_WK_KBD   = 7;
   localparam int PSW_WK_N     = 8;

   localparam logic [7:0] PSW_WK_S5_MASK = 8'h0F;
   localparam logic [7:0] PSW_WK_LP_MASK = 8'h0C;

   // configuration bits
   typedef struct packed
   {
      logic       pm_en;
      logic       s5_lan_pme_en;
      logic [1:0] apf_mode;
      logic [31:0] idle_cycles;
   } psw_cfg_s;

   // power rail controls
   typedef struct packed
   {
      logic psu_on;
      logic ctx_keep;
      logic dev_pwr;
      logic monitor_on;
      logic sys_fan_on;
      logic psu_fan_on;
   } psw_pwr_s;

endpackage : psw_pkg

/* File: hw/psw_hold_timer.sv */
/*
 power switch synchroniser, debouncer and hold timer.
 assumes the switch pin is asynchronous, active high when pressed.
*/
`timescale 1ns/10ps
module psw_hold_timer
   import psw_pkg::*;
#(
   parameter int unsigned HOLD_CYC = 32'(PSW_HOLD_CYC_L),
   parameter int unsigned DEB_CYC  = PSW_DEB_CYC
)
(
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   // switch pin
   input  wire logic i_sw,
   // press result, one-cycle pulses
   output logic      o_short,
   output logic      o_long
);
   logic                 s1_r, s2_r, deb_r, long_done_r;
   logic [PSW_CNT_W-1:0] deb_cnt_r, hold_cnt_r;

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
      end
      else
      begin
         s1_r <= i_sw;
         s2_r <= s1_r;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         deb_r     <= 1'b0;
         deb_cnt_r <= '0;
      end
      else if (s2_r == deb_r)
         deb_cnt_r <= '0;
      else if (deb_cnt_r >= PSW_CNT_W'(DEB_CYC - 1))
      begin
         deb_r     <= s2_r;
         deb_cnt_r <= '0;
      end
      else
         deb_cnt_r <= deb_cnt_r + 1'b1;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         hold_cnt_r  <= '0;
         long_done_r <= 1'b0;
         o_short     <= 1'b0;
         o_long      <= 1'b0;
      end
      else
      begin
         o_short <= 1'b0;
         o_long  <= 1'b0;
         if (deb_r)
         begin
            if (hold_cnt_r >= PSW_CNT_W'(HOLD_CYC - 1))
            begin
               if (!long_done_r)
                  o_long <= 1'b1;
               long_done_r <= 1'b1;
            end
            else
               hold_cnt_r <= hold_cnt_r + 1'b1;
         end
         else
         begin
            if (hold_cnt_r != '0 && !long_done_r)
               o_short <= 1'b1;
            hold_cnt_r  <= '0;
            long_done_r <= 1'b0;
         end
      end
   end

endmodule : psw_hold_timer

/* File: hw/psw_wake_ctrl.sv */
/*
 power switch and wake control: power state machine, wake gating,
 apm standby, soft-off, after-power-failure restore, fan switching.
 assumes a standby clock and a standby power-good reset; wake inputs
 arrive asynchronously and are synchronised here.
*/
// Functional notes
// - next state from current state and switch hold against four seconds
// - short press: off to on, working to sleep, sleep to working
// - suspend-to-RAM keeps memory context for resume
// - soft-off keeps no context; return is a cold boot
// - in S3 only wake logic and ctx_keep stay powered; in S5 only wake logic
// - switch, rtc, lan, pme wake from S1, S3, S5
// - ring, ir, usb, keyboard wake only from S1 and S3 (keyboard also leaves standby)
// - lan and pme in S5 need an enable, default off
// - with pm on, standby after idle time-out or os request
// - keyboard or mouse activity leaves standby, monitor on
// - soft-off command with pm on turns the supply off
// - after outage restore previous on/off per policy
// - fans switched by state; tach inputs for both fans
`timescale 1ns/10ps
module psw_wake_ctrl
   import psw_pkg::*;
#(
   parameter int unsigned HOLD_CYC = 32'(PSW_HOLD_CYC_L),
   parameter int unsigned DEB_CYC  = PSW_DEB_CYC
)
(
   // clock and reset
   input  wire logic            i_clk,
   input  wire logic            i_reset_n,
   // configuration
   input  wire psw_pkg::psw_cfg_s i_cfg,
   input  wire logic            i_last_on,
   // pins
   input  wire logic            i_pwr_sw,
   input  wire logic [7:0]      i_wake,
   input  wire logic            i_mouse_act,
   input  wire logic            i_sys_fan_tach,
   input  wire logic            i_psu_fan_tach,
   // os requests, same clock
   input  wire logic            i_os_sleep_s1,
   input  wire logic            i_os_sleep_s3,
   input  wire logic            i_os_standby,
   input  wire logic            i_os_soft_off,
   input  wire logic            i_activity,
   // outputs
   output psw_pkg::psw_pwr_s    o_pwr,
   output psw_pkg::psw_state_e  o_state,
   output logic                 o_cold_boot,
   output logic                 o_sys_fan_tach,
   output logic                 o_psu_fan_tach
);
   psw_state_e           state_r, state_nxt, state_in;
   logic                 sw_short, sw_long, init_r, boot_nxt, apf_on;
   logic [10:0]          a1_r, a2_r;
   logic [7:0]           wk_ok;
   logic [31:0]          idle_r;
   logic                 idle_hit;

   psw_hold_timer #(.HOLD_CYC(HOLD_CYC), .DEB_CYC(DEB_CYC)) u_hold
   (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_sw      (i_pwr_sw),
      .o_short   (sw_short),
      .o_long    (sw_long)
   );

   // two-stage sync for wake, mouse and tach pins
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         a1_r <= '0;
         a2_r <= '0;
      end
      else
      begin
         a1_r <= {i_psu_fan_tach, i_sys_fan_tach, i_mouse_act, i_wake};
         a2_r <= a1_r;
      end
   end

   assign o_sys_fan_tach = a2_r[9];
   assign o_psu_fan_tach = a2_r[10];

   always_comb
   begin
      wk_ok = '0;
      case (state_r)
         PSW_S1, PSW_S3: wk_ok = a2_r[7:0];
         // ring, ir, usb, kbd masked in s5
         // lan and pme need s5 enable
         PSW_S5:
            wk_ok = a2_r[7:0] & (PSW_WK_S5_MASK &
                    (i_cfg.s5_lan_pme_en ? 8'hFF : ~PSW_WK_LP_MASK));
         default: wk_ok = '0;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n || i_activity || state_r != PSW_S0)
         idle_r <= '0;
      else if (!idle_hit)
         idle_r <= idle_r + 1'b1;
   end
   assign idle_hit = (i_cfg.idle_cycles != '0) &&
                     (idle_r >= i_cfg.idle_cycles);

   // next state from state and press length
   always_comb
   begin
      state_nxt = state_r;
      boot_nxt  = 1'b0;
      case (state_r)
         PSW_S0:
         begin
            if (sw_long)
               state_nxt = PSW_S5;
            else if (i_os_soft_off && i_cfg.pm_en)
               state_nxt = PSW_S5;
            else if (sw_short || i_os_sleep_s1)
               state_nxt = PSW_S1;
            else if (i_os_sleep_s3)
               state_nxt = PSW_S3;
            else if (i_cfg.pm_en && (i_os_standby || idle_hit))
               state_nxt = PSW_STB;
         end
         PSW_S1, PSW_S3:
         begin
            if (sw_long)
               state_nxt = PSW_S5;
            else if (sw_short || wk_ok != '0)
               state_nxt = PSW_S0;
         end
         PSW_S5:
         begin
            // wake from off is a cold boot
            if (sw_short || wk_ok != '0)
            begin
               state_nxt = PSW_S0;
               boot_nxt  = 1'b1;
            end
         end
         PSW_STB:
         begin
            if (sw_long)
               state_nxt = PSW_S5;
            else if (a2_r[PSW_WK_KBD] || a2_r[8] || i_activity)
               state_nxt = PSW_S0;
            else if (i_os_soft_off && i_cfg.pm_en)
               state_nxt = PSW_S5;
         end
         default: state_nxt = PSW_S5;
      endcase
   end

   // outage policy applied on the first cycle after reset
   assign apf_on = (i_cfg.apf_mode == PSW_APF_ON) ||
                   (i_cfg.apf_mode == PSW_APF_LAST && i_last_on);
   // one next-state value shared by state and rails, so they never split
   assign state_in = init_r ? (apf_on ? PSW_S0 : PSW_S5) : state_nxt;

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         state_r     <= PSW_S5;
         init_r      <= 1'b1;
         o_cold_boot <= 1'b0;
      end
      else
      begin
         state_r     <= state_in;
         init_r      <= 1'b0;
         o_cold_boot <= init_r ? apf_on : boot_nxt;
      end
   end

   assign o_state = state_r;

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
         o_pwr <= '0;
      else
      begin
         o_pwr.psu_on     <= (state_in == PSW_S0 || state_in == PSW_S1 ||
                              state_in == PSW_STB);
         o_pwr.ctx_keep   <= (state_in != PSW_S5);
         o_pwr.dev_pwr    <= (state_in == PSW_S0 || state_in == PSW_STB);
         o_pwr.monitor_on <= (state_in == PSW_S0);
         o_pwr.sys_fan_on <= (state_in == PSW_S0 || state_in == PSW_STB);
         o_pwr.psu_fan_on <= (state_in == PSW_S0 || state_in == PSW_STB ||
                              state_in == PSW_S1);
      end
   end

   // assertions
   chk_long_off: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (!init_r && sw_long && state_r != PSW_S5) |=> state_r == PSW_S5)
      else $error("long press did not force soft-off");
   chk_short_on: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (!init_r && sw_short && state_r == PSW_S5)
      |=> state_r == PSW_S0 && o_cold_boot)
      else $error("short press from off did not cold boot");
   chk_s5_lowpwr: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      state_r == PSW_S5 |-> !o_pwr.dev_pwr && !o_pwr.ctx_keep)
      else $error("power left on in soft-off");
   chk_s3_ctx: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (state_r == PSW_S3 && !init_r) |-> o_pwr.ctx_keep)
      else $error("context dropped in S3");
   chk_s5_usb: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (state_r == PSW_S5 && !init_r && !sw_short
       && (a2_r[7:0] & PSW_WK_S5_MASK) == '0) |=> state_r == PSW_S5)
      else $error("illegal wake from S5");
   chk_s5_lan: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (state_r == PSW_S5 && !init_r && !i_cfg.s5_lan_pme_en && !sw_short
       && (a2_r[1:0] == '0)) |=> state_r == PSW_S5)
      else $error("lan or pme woke S5 while disabled");
   chk_soft_off: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (state_r == PSW_S0 && !init_r && i_os_soft_off && i_cfg.pm_en)
      |=> !o_pwr.psu_on)
      else $error("soft-off command ignored");
   chk_stb_exit: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (state_r == PSW_STB && !init_r && !sw_long
       && (a2_r[PSW_WK_KBD] || a2_r[8] || i_activity))
      |=> o_pwr.monitor_on)
      else $error("standby exit did not restore monitor");
   chk_fan_s0: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (state_r == PSW_S0 && $past(state_r) == PSW_S0) |-> o_pwr.sys_fan_on)
      else $error("system fan off while working");
   cov_sleep: cover property (@(posedge i_clk) state_r == PSW_S1);
   cov_s3: cover property (@(posedge i_clk) state_r == PSW_S3);
   cov_stb: cover property (@(posedge i_clk) state_r == PSW_STB);
   cov_boot: cover property (@(posedge i_clk) o_cold_boot);

endmodule : psw_wake_ctrl

/* File: verification/psw_far_side.sv */
/*
 far side model: front panel switch, supply rail and fan tachometers.
 assumes the bench pulses i_go for one cycle with the hold length set.
*/
`timescale 1ns/10ps
module psw_far_side
   import psw_pkg::*;
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_reset_n,
   // switch command
   input  wire logic              i_go,
   input  wire logic [7:0]        i_len,
   // rail controls
   input  wire psw_pkg::psw_pwr_s i_pwr,
   // far side pins
   output logic                   o_sw,
   output logic                   o_rail,
   output logic                   o_sys_tach,
   output logic                   o_psu_tach
);
   import psw_pkg::*;
   logic [7:0] hold_r;

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
         hold_r <= 8'h00;
      else
         hold_r <= i_go ? i_len : (hold_r != 8'h00 ? hold_r - 8'h01 : 8'h00);
   end
   assign o_sw = (hold_r != 8'h00);

   assign o_rail = i_pwr.psu_on;

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         o_sys_tach <= 1'b0;
         o_psu_tach <= 1'b0;
      end
      else
      begin
         o_sys_tach <= i_pwr.sys_fan_on & ~o_sys_tach;
         o_psu_tach <= i_pwr.psu_fan_on & ~o_psu_tach;
      end
   end
endmodule : psw_far_side

/* File: verification/test_power_switch_wake_control.sv */
/*
 bench for the power switch and wake control block.
 assumes short hold and debounce counts of 20 and 2 cycles.
*/
`timescale 1ns/10ps
module test_power_switch_wake_control;
   import psw_pkg::*;
   logic       i_clk = 0, i_reset_n = 0, last_on = 0, go = 0;
   logic       sw, rail, st, pt, stx, ptx, cb_p;
   // os requests: sleep s1, sleep s3, standby, soft-off, activity
   logic [4:0] req = 0;
   localparam int Q_S1 = 0, Q_S3 = 1, Q_STB = 2, Q_OFF = 3, Q_ACT = 4;
   logic [7:0] len = 0, wake = 0;
   logic       mouse = 0;
   psw_cfg_s   cfg = '{1'b1, 1'b0, PSW_APF_OFF, 32'h0000_0000};
   psw_pwr_s   pwr;
   psw_state_e state;
   int         error_cnt = 0, n_tests = 0, cb = 0;

   always #5 i_clk = ~i_clk;
   always @(posedge i_clk) if (cb_p === 1'b1) cb++;

   psw_far_side far (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_go(go),
      .i_len(len), .i_pwr(pwr), .o_sw(sw), .o_rail(rail), .o_sys_tach(st),
      .o_psu_tach(pt));

   psw_wake_ctrl #(.HOLD_CYC(20), .DEB_CYC(2)) dut (.i_clk(i_clk),
      .i_reset_n(i_reset_n), .i_cfg(cfg), .i_last_on(last_on),
      .i_pwr_sw(sw), .i_wake(wake), .i_mouse_act(mouse),
      .i_sys_fan_tach(st), .i_psu_fan_tach(pt), .i_os_sleep_s1(req[Q_S1]),
      .i_os_sleep_s3(req[Q_S3]), .i_os_standby(req[Q_STB]),
      .i_os_soft_off(req[Q_OFF]), .i_activity(req[Q_ACT]), .o_pwr(pwr),
      .o_state(state), .o_cold_boot(cb_p), .o_sys_fan_tach(stx),
      .o_psu_fan_tach(ptx));

   task end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim

   task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("wrong value %s exp %h got %h", nm, exp, got);
         error_cnt++;
      end
   endtask : chk

   task wait_st(input psw_state_e exp);
      int i;
      for (i = 0; i < 300 && state !== exp; i++) @(posedge i_clk);
      chk("state", 8'(exp), 8'(state));
      if (state !== exp) end_sim();
      @(posedge i_clk);
   endtask : wait_st

   task press(input logic [7:0] n);
      @(posedge i_clk) {go, len} <= {1'b1, n};
      @(posedge i_clk) go <= 1'b0;
   endtask : press

   task wk(input int b);
      @(posedge i_clk) wake[b] <= 1'b1;
      repeat (6) @(posedge i_clk);
      wake[b] <= 1'b0;
      repeat (20) @(posedge i_clk);
   endtask : wk

   task pulse(input int b);
      @(posedge i_clk) req[b] <= 1'b1;
      @(posedge i_clk) req[b] <= 1'b0;
   endtask : pulse

   // running fan toggles its tach every cycle, a stopped one stays low
   task chk_tach(input logic [1:0] run);
      logic [1:0] t0;
      repeat (4) @(posedge i_clk);
      t0 = {stx, ptx};
      @(posedge i_clk);
      chk("tach run", {6'h00, run}, {6'h00, t0 ^ {stx, ptx}});
      chk("tach idle", 8'h00, {6'h00, (t0 | {stx, ptx}) & ~run});
   endtask : chk_tach

   task t_power_on;
      chk("off rail", 8'h00, 8'(pwr.dev_pwr));
      press(8'h08);
      wait_st(PSW_S0);
      chk("cold boot", 8'h01, 8'(cb));
      chk("rail", 8'h01, 8'(rail));
      chk("fans", 8'h03, {6'h00, pwr.sys_fan_on, pwr.psu_fan_on});
      chk_tach(2'b11);
   endtask : t_power_on

   task t_sleep;
      press(8'h08);
      wait_st(PSW_S1);
      wk(PSW_WK_USB);
      wait_st(PSW_S0);
      pulse(Q_S3);
      wait_st(PSW_S3);
      chk("s3 ctx", 8'h01, 8'(pwr.ctx_keep));
      chk("s3 dev", 8'h00, 8'(pwr.dev_pwr));
      chk("s3 fan", 8'h00, 8'(pwr.sys_fan_on));
      chk_tach(2'b00);
      wk(PSW_WK_RING);
      wait_st(PSW_S0);
      chk("warm resume", 8'h01, 8'(cb));
   endtask : t_sleep

   task t_s5_wake;
      press(8'h3C);
      wait_st(PSW_S5);
      chk("s5 ctx", 8'h00, 8'(pwr.ctx_keep));
      wk(PSW_WK_KBD);
      wk(PSW_WK_LAN);
      chk("s5 refuse", 8'(PSW_S5), 8'(state));
      @(posedge i_clk) cfg.s5_lan_pme_en <= 1'b1;
      wk(PSW_WK_PME);
      wait_st(PSW_S0);
      pulse(Q_S1);
      wait_st(PSW_S1);
      press(8'h3C);
      wait_st(PSW_S5);
      wk(PSW_WK_RTC);
      wait_st(PSW_S0);
      chk("cold boots", 8'h03, 8'(cb));
   endtask : t_s5_wake

   task t_apm;
      @(posedge i_clk) cfg.idle_cycles <= 32'h0000_001E;
      wait_st(PSW_STB);
      @(posedge i_clk) cfg.idle_cycles <= 32'h0000_0000;
      @(posedge i_clk) mouse <= 1'b1;
      wait_st(PSW_S0);
      @(posedge i_clk) mouse <= 1'b0;
      chk("monitor", 8'h01, 8'(pwr.monitor_on));
      pulse(Q_STB);
      wait_st(PSW_STB);
      wk(PSW_WK_KBD);
      wait_st(PSW_S0);
      pulse(Q_STB);
      wait_st(PSW_STB);
      pulse(Q_ACT);
      wait_st(PSW_S0);
      @(posedge i_clk) cfg.pm_en <= 1'b0;
      pulse(Q_STB);
      pulse(Q_OFF);
      repeat (4) @(posedge i_clk);
      chk("pm off", 8'(PSW_S0), 8'(state));
      @(posedge i_clk) cfg.pm_en <= 1'b1;
      pulse(Q_OFF);
      wait_st(PSW_S5);
      chk("rail off", 8'h00, 8'(rail));
   endtask : t_apm

   task t_restore;
      @(posedge i_clk) {cfg.apf_mode, last_on, i_reset_n} <= {PSW_APF_LAST,
         2'b10};
      repeat (20) @(posedge i_clk);
      i_reset_n <= 1'b1;
      wait_st(PSW_S0);
      chk("restore boot", 8'h04, 8'(cb));
      @(posedge i_clk) {last_on, i_reset_n} <= 2'b00;
      repeat (20) @(posedge i_clk);
      i_reset_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      chk("restore off", 8'(PSW_S5), 8'(state));
      chk("no boot", 8'h04, 8'(cb));
   endtask : t_restore

   initial
   begin
      repeat (20) @(posedge i_clk);
      i_reset_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      chk("reset state", 8'(PSW_S5), 8'(state));
      t_power_on();
      t_sleep();
      t_s5_wake();
      t_apm();
      t_restore();
      end_sim();
   end
endmodule : test_power_switch_wake_control
